// >>> shared/mss_pkg.sv
// Shared constants and types of the multi-step speed sequencer
package mss_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int TENTH_S_CYC = TENTH_S_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_MIN_TENTH = 60;
   localparam int SYNC_STAGES = 3;

   // ****************************************
   // Widths and ranges
   // ****************************************
   localparam int NUM_STEPS = 16;
   localparam int STEP_W = 4;
   localparam int SPEED_W = 11;
   localparam int SPEED_IN_W = 16;
   localparam int TIME_W = 16;
   localparam int FREQ_W = 16;
   localparam int FREF_W = 17;
   localparam int PROD_W = 28;
   localparam logic signed [SPEED_IN_W-1:0] SPEED_MAX = 16'sh03e8;
   localparam logic signed [SPEED_IN_W-1:0] SPEED_MIN = -16'sh03e8;
   localparam logic signed [PROD_W-1:0] FULL_SCALE = 28'sh00003e8;
   localparam logic [STEP_W-1:0] FIRST_STEP = 4'h0;
   localparam logic [STEP_W-1:0] LAST_STEP = 4'hf;
   localparam logic [3:0] SEL_NONE = 4'h0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic signed [SPEED_W-1:0] SPEED_RST = 11'sh000;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
   localparam logic signed [FREF_W-1:0] FREF_RST = 17'sh00000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      CYC_STOP = 2'b00,
      CYC_HOLD = 2'b01,
      CYC_LOOP = 2'b10
   } mss_cycle_e;

   typedef enum logic [1:0] {
      CHAN_KEYPAD = 2'b00,
      CHAN_TERMINAL = 2'b01,
      CHAN_COMM = 2'b10
   } mss_chan_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b10,
      ST_DONE = 2'b11
   } mss_state_e;

   typedef struct packed {
      logic signed [SPEED_W-1:0] speed;
      logic [TIME_W-1:0] run_time;
   } mss_step_s;

   typedef struct packed {
      logic [STEP_W-1:0] step;
      logic signed [FREF_W-1:0] freq;
   } mss_snap_s;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic signed [FREF_W-1:0] mss_scale(
      input logic signed [SPEED_W-1:0] spd,
      input logic [FREQ_W-1:0] fmax
   );
      logic signed [PROD_W-1:0] prod;
      prod = PROD_W'(spd) * $signed({12'h000, fmax});
      return FREF_W'(prod / FULL_SCALE);
   endfunction

   function automatic logic signed [SPEED_W-1:0] mss_clamp(
      input logic signed [SPEED_IN_W-1:0] spd
   );
      logic signed [SPEED_IN_W-1:0] lim;
      lim = spd;
      if (spd > SPEED_MAX) begin
         lim = SPEED_MAX;
      end else if (spd < SPEED_MIN) begin
         lim = SPEED_MIN;
      end
      return SPEED_W'(lim);
   endfunction

endpackage

// >>> src/mss_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module mss_sync
   import mss_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins in, clean levels out
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] meta;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // ****************************************
   // Sync chain
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         meta <= pin_i;
         s2 <= meta;
         s3 <= s2;
      end
   end

   // Accept change when stages agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               level_o[i] <= s3[i];
            end
         end
      end
   end

endmodule // mss_sync
`default_nettype wire

// >>> src/mss_sequencer.sv
// Multi-step speed sequencer driving a drive frequency reference
//
// What this block does
// - Cycle mode 0 stops the drive after one pass and waits for a fresh run command.
// - Cycle mode 1 keeps the last step's frequency and direction after one pass.
// - Cycle mode 2 restarts at step 0 after each pass until a stop command.
// - Retention 0 keeps nothing at power loss; 1 saves and restores step index and frequency.
// - Step speeds span -100.0 to 100.0 percent, full scale meaning maximum output frequency.
// - Step run times span 0.0 to 6553.5 in tenths, in seconds or minutes by the unit setting.
// - A negative step speed commands reverse running, otherwise forward.
// - Sixteen steps 0 to 15 each hold their own speed and run time.
// - The step setpoint is continuously adjustable between minus and plus maximum frequency.
// - Start and stop follow the selected run command channel.
// - Any active step-select input makes the speed of the step whose number the four pins encode as a binary code override every other source.
// - With no step-select input active and the sequencer not running or holding, the main or auxiliary source sets the reference.
`timescale 1ns/1ns
`default_nettype none
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int TENTH_CYC = TENTH_S_CYC
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // Step programming
   input wire logic STEP_WR_I,
   input wire logic [STEP_W-1:0] STEP_IDX_I,
   input wire logic signed [SPEED_IN_W-1:0] STEP_SPEED_I,
   input wire logic [TIME_W-1:0] STEP_TIME_I,
   // Configuration
   input wire logic [1:0] CYCLE_MODE_SELECT_I,
   input wire logic POWER_LOSS_RETENTION_SELECT_I,
   input wire logic STEP_TIME_UNIT_SELECT_I,
   input wire logic [1:0] RUN_COMMAND_CHANNEL_SELECT_I,
   input wire logic [FREQ_W-1:0] MAX_OUTPUT_FREQUENCY_I,
   input wire logic SEQ_ENABLE_I,
   input wire logic FREQ_SOURCE_SECONDARY_I,
   // Run commands
   input wire logic RUN_KEYPAD_I,
   input wire logic RUN_TERMINAL_I,
   input wire logic RUN_COMM_I,
   // Step-select pins
   input wire logic [3:0] STEP_SELECT_I,
   // Frequency sources
   input wire logic signed [FREF_W-1:0] PRIMARY_FREQUENCY_SOURCE_I,
   input wire logic signed [FREF_W-1:0] SECONDARY_FREQUENCY_SOURCE_I,
   // Retention store
   input wire logic POWER_FAIL_I,
   input wire mss_snap_s RESTORE_I,
   input wire logic RESTORE_VALID_I,
   output mss_snap_s SNAP_O,
   output logic SNAP_VALID_O,
   // Drive outputs
   output logic signed [FREF_W-1:0] FREQ_REF_O,
   output logic REVERSE_O,
   output logic RUN_O,
   output logic [STEP_W-1:0] STEP_O,
   output logic PASS_DONE_O
);

   // ****************************************
   // Declarations
   // ****************************************
   mss_step_s steps [NUM_STEPS];
   mss_state_e state;
   mss_state_e next_state;
   logic [5:0] pin_sync;
   logic run_term;
   logic [3:0] sel;
   logic pwr_fail;
   logic pwr_fail_d;
   logic run_req;
   logic [STEP_W-1:0] cur_step;
   logic [STEP_W-1:0] next_step;
   logic load_step;
   logic [31:0] presc;
   logic [5:0] min_cnt;
   logic unit_tick;
   logic [TIME_W-1:0] elapsed;
   logic step_end;
   logic last_step;
   logic restore_taken;
   logic rest_valid;
   mss_snap_s rest;
   logic use_rest;
   logic signed [FREF_W-1:0] seq_freq;
   logic signed [FREF_W-1:0] next_freq;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   mss_sync #(
      .W(6)
   ) u_sync (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i({POWER_FAIL_I, STEP_SELECT_I, RUN_TERMINAL_I}),
      .level_o(pin_sync)
   );
   assign run_term = pin_sync[0];
   assign sel = pin_sync[4:1];
   assign pwr_fail = pin_sync[5];

   always_comb begin
      unique case (mss_chan_e'(RUN_COMMAND_CHANNEL_SELECT_I))
         CHAN_KEYPAD: run_req = RUN_KEYPAD_I;
         CHAN_TERMINAL: run_req = run_term;
         CHAN_COMM: run_req = RUN_COMM_I;
         default: run_req = 1'b0;
      endcase
   end

   // ****************************************
   // Step table
   // ****************************************
   // sixteen step pairs
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < NUM_STEPS; i++) begin
            steps[i] <= '{speed: SPEED_RST, run_time: TIME_RST};
         end
      end else if (STEP_WR_I) begin
         steps[STEP_IDX_I].speed <= mss_clamp(STEP_SPEED_I);
         steps[STEP_IDX_I].run_time <= STEP_TIME_I;
      end
   end

   // ****************************************
   // Step timer
   // ****************************************
   // tenth-second base
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         presc <= '0;
      end else if (load_step || presc == 32'(TENTH_CYC - 1)) begin
         presc <= '0;
      end else begin
         presc <= presc + 32'h0000_0001;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         min_cnt <= '0;
      end else if (load_step) begin
         min_cnt <= '0;
      end else if (presc == 32'(TENTH_CYC - 1)) begin
         if (min_cnt == 6'(TENTHS_PER_MIN_TENTH - 1)) begin
            min_cnt <= '0;
         end else begin
            min_cnt <= min_cnt + 6'h01;
         end
      end
   end

   always_comb begin
      unit_tick = !load_step && presc == 32'(TENTH_CYC - 1);
      if (STEP_TIME_UNIT_SELECT_I) begin
         unit_tick = unit_tick && min_cnt == 6'(TENTHS_PER_MIN_TENTH - 1);
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         elapsed <= '0;
      end else if (load_step) begin
         elapsed <= '0;
      end else if (state == ST_RUN && unit_tick && !step_end) begin
         elapsed <= elapsed + 16'h0001;
      end
   end

   assign step_end = elapsed >= steps[cur_step].run_time;
   assign last_step = cur_step == LAST_STEP;

   // ****************************************
   // Sequencer state machine
   // ****************************************
   always_comb begin
      next_state = state;
      next_step = cur_step;
      load_step = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (run_req && SEQ_ENABLE_I) begin
               next_state = ST_RUN;
               load_step = 1'b1;
               next_step = rest_valid ? rest.step : FIRST_STEP;
            end
         end
         ST_RUN: begin
            if (!run_req || !SEQ_ENABLE_I) begin
               next_state = ST_IDLE;
            end else if (step_end) begin
               load_step = 1'b1;
               if (!last_step) begin
                  next_step = cur_step + 4'h1;
               end else begin
                  unique case (mss_cycle_e'(CYCLE_MODE_SELECT_I))
                     CYC_STOP: next_state = ST_DONE;
                     CYC_HOLD: next_state = ST_HOLD;
                     CYC_LOOP: next_step = FIRST_STEP;
                     default: next_state = ST_DONE;
                  endcase
               end
            end
         end
         ST_HOLD: begin
            if (!run_req || !SEQ_ENABLE_I) begin
               next_state = ST_IDLE;
            end
         end
         ST_DONE: begin
            if (!run_req) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_IDLE;
         cur_step <= FIRST_STEP;
      end else begin
         state <= next_state;
         cur_step <= next_step;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PASS_DONE_O <= 1'b0;
      end else begin
         PASS_DONE_O <= state == ST_RUN && run_req && SEQ_ENABLE_I && step_end && last_step;
      end
   end

   // ****************************************
   // Retention
   // ****************************************
   // catch restore after reset
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         restore_taken <= 1'b0;
         rest_valid <= 1'b0;
         rest <= '{step: FIRST_STEP, freq: FREF_RST};
      end else if (!restore_taken) begin
         restore_taken <= 1'b1;
         rest_valid <= RESTORE_VALID_I && POWER_LOSS_RETENTION_SELECT_I;
         rest <= RESTORE_I;
      end else if (state == ST_IDLE && next_state == ST_RUN) begin
         rest_valid <= 1'b0;
      end
   end

   // Restored frequency until step changes
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         use_rest <= 1'b0;
      end else if (state == ST_IDLE && next_state == ST_RUN) begin
         use_rest <= rest_valid;
      end else if (load_step || next_state == ST_IDLE) begin
         use_rest <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pwr_fail_d <= 1'b0;
         SNAP_O <= '{step: FIRST_STEP, freq: FREF_RST};
         SNAP_VALID_O <= 1'b0;
      end else begin
         pwr_fail_d <= pwr_fail;
         if (pwr_fail && !pwr_fail_d) begin
            SNAP_O <= '{step: cur_step, freq: seq_freq};
            SNAP_VALID_O <= POWER_LOSS_RETENTION_SELECT_I;
         end
      end
   end

   // ****************************************
   // Frequency reference
   // ****************************************
   // continuous scaled setpoint
   assign seq_freq = use_rest ? rest.freq
                              : mss_scale(steps[cur_step].speed, MAX_OUTPUT_FREQUENCY_I);

   always_comb begin
      next_freq = FREQ_SOURCE_SECONDARY_I ? SECONDARY_FREQUENCY_SOURCE_I
                                          : PRIMARY_FREQUENCY_SOURCE_I;
      if (next_state == ST_RUN || next_state == ST_HOLD) begin
         next_freq = (load_step ? (state == ST_IDLE && rest_valid) : use_rest) ? rest.freq
                     : mss_scale(steps[next_step].speed, MAX_OUTPUT_FREQUENCY_I);
      end
      if (sel != SEL_NONE) begin
         next_freq = mss_scale(steps[sel].speed, MAX_OUTPUT_FREQUENCY_I);
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FREQ_REF_O <= FREF_RST;
         REVERSE_O <= 1'b0;
         RUN_O <= 1'b0;
         STEP_O <= FIRST_STEP;
      end else begin
         FREQ_REF_O <= next_freq;
         REVERSE_O <= next_freq < FREF_RST;
         RUN_O <= next_state == ST_RUN || next_state == ST_HOLD;
         STEP_O <= next_step;
      end
   end

endmodule // mss_sequencer
`default_nettype wire

// >>> testbench/mss_seq_properties.sv
// Port-level concurrent checks of the step sequencer
`timescale 1ns/1ns
`default_nettype none
module mss_seq_properties
   import mss_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic [1:0] CYCLE_MODE_SELECT_I,
   input wire logic [1:0] RUN_COMMAND_CHANNEL_SELECT_I,
   input wire logic SEQ_ENABLE_I,
   input wire logic RUN_KEYPAD_I,
   input wire logic signed [FREF_W-1:0] FREQ_REF_O,
   input wire logic REVERSE_O,
   input wire logic RUN_O,
   input wire logic [STEP_W-1:0] STEP_O,
   input wire logic PASS_DONE_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic kp;
   assign kp = RUN_COMMAND_CHANNEL_SELECT_I == 2'h0 && RUN_KEYPAD_I;
   a_dir_sign: assert property (REVERSE_O == (FREQ_REF_O < 0))
      else $error("direction flag disagrees with reference sign");
   a_pass_pulse: assert property (PASS_DONE_O |=> !PASS_DONE_O)
      else $error("pass pulse longer than one cycle");
   a_pass_last: assert property (PASS_DONE_O |-> $past(STEP_O) == LAST_STEP)
      else $error("pass ended away from the last step");
   a_stop_once: assert property (PASS_DONE_O && CYCLE_MODE_SELECT_I == 2'h0 |-> ##[0:1] !RUN_O)
      else $error("stop mode kept running after a pass");
   a_hold_last: assert property (PASS_DONE_O && CYCLE_MODE_SELECT_I == 2'h1 && kp
      |=> RUN_O && STEP_O == LAST_STEP)
      else $error("hold mode left the last step");
   a_loop_wrap: assert property (PASS_DONE_O && CYCLE_MODE_SELECT_I == 2'h2 && kp
      |-> ##[0:1] (RUN_O && STEP_O == FIRST_STEP))
      else $error("loop mode did not restart at step zero");
   a_run_drop: assert property (RUN_O && RUN_COMMAND_CHANNEL_SELECT_I == 2'h0
      && !RUN_KEYPAD_I |=> !RUN_O)
      else $error("sequencer ran on without a run level");
   a_need_enable: assert property (!RUN_O && !SEQ_ENABLE_I |=> !RUN_O)
      else $error("sequencer started while not selected");
   a_step_next: assert property (RUN_O && $past(RUN_O) && STEP_O != $past(STEP_O)
      |-> STEP_O == $past(STEP_O) + 4'h1)
      else $error("step advanced out of order");
endmodule // mss_seq_properties
bind mss_sequencer mss_seq_properties i_props (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
   .CYCLE_MODE_SELECT_I(CYCLE_MODE_SELECT_I), .SEQ_ENABLE_I(SEQ_ENABLE_I),
   .RUN_COMMAND_CHANNEL_SELECT_I(RUN_COMMAND_CHANNEL_SELECT_I), .RUN_KEYPAD_I(RUN_KEYPAD_I),
   .FREQ_REF_O(FREQ_REF_O), .REVERSE_O(REVERSE_O), .RUN_O(RUN_O), .STEP_O(STEP_O),
   .PASS_DONE_O(PASS_DONE_O));
`default_nettype wire

// >>> testbench/mss_drive_model.sv
// Model of the drive's three run-command sources
`timescale 1ns/1ns
`default_nettype none
module mss_drive_model (
   // Clock and command
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [1:0] chan_i,
   // Run levels per source
   output logic run_keypad_o,
   output logic run_terminal_o,
   output logic run_comm_o
);
   logic tgl;
   initial begin
      tgl = 1'b0;
      {run_keypad_o, run_terminal_o, run_comm_o} = 3'h0;
   end
   always @(posedge clk_i) begin
      tgl <= ~tgl;
      run_keypad_o <= (chan_i == 2'h0) ? run_i : tgl;
      run_terminal_o <= (chan_i == 2'h1) ? run_i : ~tgl;
      run_comm_o <= (chan_i == 2'h2) ? run_i : tgl;
   end
endmodule // mss_drive_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the step sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mss_pkg::*;
   localparam int TC = 4;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, ret = 1'b0, unit = 1'b0, en = 1'b0;
   logic sec = 1'b0, pf = 1'b0, rv = 1'b0, run = 1'b0;
   logic [1:0] mode = 2'h0, chan = 2'h0;
   logic [3:0] idx = 4'h0, sel = 4'h0;
   logic signed [SPEED_IN_W-1:0] spd = 16'sh0000;
   logic [TIME_W-1:0] tim = 16'h0000;
   logic signed [FREF_W-1:0] pri = 17'sh00123, scd = 17'sh1ff00, fref;
   logic rk, rt, rc, rev, run_o, snapv, pdone;
   mss_snap_s rsnap = '0, snap;
   logic [STEP_W-1:0] step;
   int n_fail = 0, cmp_count = 0;
   int sp_tab [16];
   int t_tab [16];
   always #20 clk = ~clk;
   mss_drive_model i_model (.clk_i(clk), .run_i(run), .chan_i(chan),
      .run_keypad_o(rk), .run_terminal_o(rt), .run_comm_o(rc));
   mss_sequencer #(.TENTH_CYC(TC)) i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
      .STEP_WR_I(wr), .STEP_IDX_I(idx), .STEP_SPEED_I(spd), .STEP_TIME_I(tim),
      .CYCLE_MODE_SELECT_I(mode), .POWER_LOSS_RETENTION_SELECT_I(ret),
      .STEP_TIME_UNIT_SELECT_I(unit), .RUN_COMMAND_CHANNEL_SELECT_I(chan),
      .MAX_OUTPUT_FREQUENCY_I(16'h0bb7), .SEQ_ENABLE_I(en), .FREQ_SOURCE_SECONDARY_I(sec),
      .RUN_KEYPAD_I(rk), .RUN_TERMINAL_I(rt), .RUN_COMM_I(rc), .STEP_SELECT_I(sel),
      .PRIMARY_FREQUENCY_SOURCE_I(pri), .SECONDARY_FREQUENCY_SOURCE_I(scd),
      .POWER_FAIL_I(pf), .RESTORE_I(rsnap), .RESTORE_VALID_I(rv), .SNAP_O(snap),
      .SNAP_VALID_O(snapv), .FREQ_REF_O(fref), .REVERSE_O(rev), .RUN_O(run_o),
      .STEP_O(step), .PASS_DONE_O(pdone));
   function automatic logic signed [FREF_W-1:0] ef(input int s);
      return FREF_W'((s * 2999) / 1000);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic start();
      int k;
      @(posedge clk);
      run <= 1'b1;
      k = 0;
      tick(1);
      while (run_o !== 1'b1 && k < 20) begin
         tick(1);
         k++;
      end
   endtask
   task automatic stop();
      int k;
      @(posedge clk);
      run <= 1'b0;
      tick(2);
      k = 0;
      while (run_o !== 1'b0 && k < 20) begin
         tick(1);
         k++;
      end
   endtask
   task automatic wait_for(input logic [3:0] i);
      int k;
      k = 0;
      while (step !== i && k < 600) begin
         tick(1);
         k++;
      end
      check("step reached", step, i);
   endtask
   task automatic seq(input int mul, input bit hold);
      int k;
      for (int i = 0; i < 16; i++) begin
         wait_for(4'(i));
         check("step freq", fref, ef(sp_tab[i]));
         check("step dir", rev, sp_tab[i] < 0);
         k = 0;
         while (step === 4'(i) && run_o === 1'b1 && k < 600) begin
            tick(1);
            k++;
         end
         if (!(hold && i == 15)) check("step length", k, t_tab[i] * TC * mul + 1);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
      check("idle primary", fref, pri);
      sec <= 1'b1;
      tick(2);
      check("idle secondary", fref, scd);
      sec <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         sp_tab[i] = (i == 15) ? 1500 : (i == 14) ? -1500 : i * 133 - 1000;
         t_tab[i] = i % 3;
         @(posedge clk);
         wr <= 1'b1;
         idx <= 4'(i);
         spd <= 16'(sp_tab[i]);
         tim <= 16'(t_tab[i]);
         sp_tab[i] = sp_tab[i] > 1000 ? 1000 : sp_tab[i] < -1000 ? -1000 : sp_tab[i];
      end
      @(posedge clk);
      wr <= 1'b0;
      start();
      check("run without enable", run_o, 1'b0);
      stop();
      en <= 1'b1;
      start();
      seq(1, 1'b0);
      tick(10);
      check("stopped after pass", run_o, 1'b0);
      stop();
      start();
      check("fresh run restarts", run_o, 1'b1);
      stop();
      $display("test stop mode done");
      mode <= 2'h1;
      start();
      seq(1, 1'b1);
      tick(20);
      check("hold run", run_o, 1'b1);
      check("hold freq", fref, ef(sp_tab[15]));
      check("hold dir", rev, 1'b0);
      ret <= 1'b1;
      pf <= 1'b1;
      tick(8);
      check("snap valid", snapv, 1'b1);
      check("snap step", snap.step, 4'hf);
      check("snap freq", snap.freq, ef(sp_tab[15]));
      stop();
      $display("test hold mode done");
      mode <= 2'h2;
      unit <= 1'b1;
      start();
      seq(60, 1'b0);
      wait_for(4'h0);
      check("loop restarted", run_o, 1'b1);
      stop();
      check("stop to primary", fref, pri);
      unit <= 1'b0;
      mode <= 2'h0;
      $display("test loop mode done");
      for (int c = 1; c < 4; c++) begin
         chan <= 2'(c);
         start();
         check("channel run", run_o, c != 3);
         stop();
      end
      chan <= 2'h0;
      sel <= 4'h5;
      tick(8);
      check("select 5", fref, ef(sp_tab[5]));
      sel <= 4'he;
      tick(8);
      check("select 14", fref, ef(sp_tab[14]));
      check("select dir", rev, 1'b1);
      sel <= 4'h0;
      tick(8);
      check("select off", fref, pri);
      $display("test sources done");
      mode <= 2'h3;
      rst_n <= 1'b0;
      pf <= 1'b0;
      rsnap <= '{step: 4'h9, freq: 17'sh00abc};
      rv <= 1'b1;
      tick(3);
      check("snap cleared", snapv, 1'b0);
      rst_n <= 1'b1;
      tick(8);
      start();
      check("restored step", step, 4'h9);
      check("restored freq", fref, 17'sh00abc);
      tick(20);
      check("spare mode stops", run_o, 1'b0);
      stop();
      ret <= 1'b0;
      pf <= 1'b1;
      tick(8);
      check("no retention", snapv, 1'b0);
      $display("test retention done");
      final_report();
   end
endmodule // tb
`default_nettype wire
